// ### rtl/cmd_decoder_pkg.sv
// Shared types and constants of the memory command decoder.
// Assumes a single 125 MHz clock and the usual active-low command pins.
`default_nettype none

package cmd_decoder_pkg;

  // ---------------------------------------------------------------------------
  // Pin widths and field positions
  // ---------------------------------------------------------------------------
  localparam int BANK_W = 3;
  localparam int ADDR_W = 15;
  localparam int AP_BIT = 10;                 // Auto precharge / all banks / long calibration.
  localparam int BC_BIT = 12;                 // Burst chop select on the fly.
  localparam int BL_LSB = 0;                  // Burst length field in mode register zero.
  localparam logic [BANK_W-1:0] MR0_SEL = 3'h0;

  // Burst length field encodings.
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] BL_RESET = BL_FIXED8;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BEATS8 = 4;                  // Clocks of data for an eight-beat burst.
  localparam int BEATS4 = 2;                  // Clocks of data for a chopped burst.
  localparam int SRX_WRITE_NCK = 512;         // Cycles after self refresh exit before writes.

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    cmd_none, cmd_mode_set, cmd_refresh, cmd_sr_entry, cmd_sr_exit,
    cmd_precharge, cmd_precharge_all, cmd_activate, cmd_write, cmd_read,
    cmd_nop, cmd_deselect, cmd_pd_entry, cmd_pd_exit, cmd_zq_long,
    cmd_zq_short
  } cmd_t;

  typedef enum logic [1:0] {
    st_active, st_power_down, st_self_refresh, st_illegal
  } pwr_t;

  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic cke;
    logic odt;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } pins_t;

  typedef struct packed {
    cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic auto_pre;
    logic chop4;
  } cmd_info_t;

endpackage : cmd_decoder_pkg

`default_nettype wire

// ### rtl/pin_sync.sv
// Two-stage synchroniser for a group of pins.
// Assumes the pins are asynchronous to clock; the first stage feeds only the second.
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 24
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_q_b,
  // Pins in and synchronised copy out.
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync needs at least one bit");
  end

  // ---------------------------------------------------------------------------
  // Two flip-flops per bit.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ### rtl/burst_tracker.sv
// Tracks the data phase of a read or write burst.
// Assumes start pulses come from the decoder on the same clock.
`default_nettype none

module burst_tracker #(
  parameter int BEATS_MAX = cmd_decoder_pkg::BEATS8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_q_b,
  // Burst start request.
  input wire logic start,
  input wire logic chop4,
  // Burst state.
  output var logic busy,
  output var logic overlap
);

  localparam int CW = $clog2(BEATS_MAX + 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic overlap_next;
  logic can_start;

  if (BEATS_MAX < cmd_decoder_pkg::BEATS8) begin : g_chk
    $error("burst_tracker too short for an eight-beat burst");
  end

  // ---------------------------------------------------------------------------
  // Count down; a burst runs to its end, a new one joins only on the last beat.
  // ---------------------------------------------------------------------------
  always_comb begin
    can_start = (cnt_reg <= CW'(1));
    cnt_next = (cnt_reg != '0) ? cnt_reg - CW'(1) : cnt_reg;
    overlap_next = 1'b0;
    if (start && can_start) begin
      cnt_next = chop4 ? CW'(cmd_decoder_pkg::BEATS4) : CW'(cmd_decoder_pkg::BEATS8);
    end else if (start) begin
      overlap_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      overlap <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy <= (cnt_next != '0);
      overlap <= overlap_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_q_b);

  burst_runs_on_a: assert property ((cnt_reg > CW'(1)) |=> (cnt_reg == $past(cnt_reg) - CW'(1)))
    else $error("burst cut short");

endmodule : burst_tracker

`default_nettype wire

// ### rtl/cmd_decoder.sv
// Command decoder of a synchronous memory device.
// Assumes the command pins arrive asynchronously and a single 125 MHz clock.
//
// How it works
// - Commands decode from CS, RAS, CAS, WE and CKE sampled on clock rise, with A10 splitting precharge and calibration.
// - Bank-oriented commands take the bank address to pick the bank.
// - Mode set uses bank address as register select, other address bits as opcode.
// - Bursts never end early; fixed or on-the-fly length follows the mode register.
// - No refresh is performed while in power-down.
// - Termination input never steers decoding; termination is off in self refresh.
// - Self refresh exit is recognised from the CKE rise alone.
// - CS low with RAS, CAS, WE high and CKE high is a no-op.
// - A no-op never terminates an operation still running.
// - CS high is deselect, ignores other inputs, acts as a no-op.
// - Write is RAS high, CAS low, WE low; A10 auto precharge, A12 chop.
// - Read is RAS high, CAS low, WE high with the same address fields.
// - A10 high on read or write requests auto precharge after the burst.
// - RAS low, CAS high, WE high with CKE high opens a row.
`default_nettype none

module cmd_decoder (
  // Clock and asynchronous reset pin.
  input wire logic clock,
  input wire logic rst_b,
  // Command pins, all active-low strobes except cke and odt.
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic cke,
  input wire logic odt,
  input wire logic [cmd_decoder_pkg::BANK_W-1:0] ba,
  input wire logic [cmd_decoder_pkg::ADDR_W-1:0] addr,
  // Decoded command, one-cycle valid.
  output var cmd_decoder_pkg::cmd_info_t cmd_out,
  output var logic cmd_valid,
  output var logic illegal,
  // Device state.
  output var logic in_power_down,
  output var logic in_self_refresh,
  output var logic refresh_go,
  output var logic term_on,
  output var logic write_hold,
  output var logic burst_busy,
  output var logic burst_overlap,
  output var logic [1:0] burst_mode
);

  // ---------------------------------------------------------------------------
  // Reset release and pin synchronisation
  // ---------------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_q_b;
  logic [$bits(cmd_decoder_pkg::pins_t)-1:0] pins_raw;
  cmd_decoder_pkg::pins_t pins;
  logic [$bits(cmd_decoder_pkg::pins_t)-1:0] pins_bits;

  // Reset asserts at once and releases through two flip-flops.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_q_b <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_q_b <= rst_meta_reg;
    end
  end

  // The synchroniser resets to zeros; folding this pattern in and out turns that into a
  // deselect with CKE high, so no false CKE rise or illegal pulse follows reset.
  localparam cmd_decoder_pkg::pins_t PINS_IDLE = '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1,
                                                   we_b: 1'b1, cke: 1'b1, default: '0};

  assign pins_raw = {cs_b, ras_b, cas_b, we_b, cke, odt, ba, addr} ^ PINS_IDLE;
  assign pins = cmd_decoder_pkg::pins_t'(pins_bits ^ PINS_IDLE);

  pin_sync #(
    .WIDTH($bits(cmd_decoder_pkg::pins_t))
  ) u_sync (
    .clock(clock),
    .rst_q_b(rst_q_b),
    .d(pins_raw),
    .q(pins_bits)
  );

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  // Maps the strobes and both CKE samples onto a command; odt is never looked at.
  function automatic cmd_decoder_pkg::cmd_t decode(
    input cmd_decoder_pkg::pins_t p,
    input logic cke_prev,
    input cmd_decoder_pkg::pwr_t st
  );
    cmd_decoder_pkg::cmd_t c;
    logic quiet;
    c = cmd_decoder_pkg::cmd_none;
    quiet = p.cs_b || ({p.ras_b, p.cas_b, p.we_b} == 3'h7);
    if (cke_prev && p.cke) begin
      if (p.cs_b) begin
        c = cmd_decoder_pkg::cmd_deselect;
      end else begin
        case ({p.ras_b, p.cas_b, p.we_b})
          3'h0: c = cmd_decoder_pkg::cmd_mode_set;
          3'h1: c = cmd_decoder_pkg::cmd_refresh;
          3'h2: c = p.addr[cmd_decoder_pkg::AP_BIT] ? cmd_decoder_pkg::cmd_precharge_all
                                                     : cmd_decoder_pkg::cmd_precharge;
          3'h3: c = cmd_decoder_pkg::cmd_activate;
          3'h4: c = cmd_decoder_pkg::cmd_write;
          3'h5: c = cmd_decoder_pkg::cmd_read;
          3'h6: c = p.addr[cmd_decoder_pkg::AP_BIT] ? cmd_decoder_pkg::cmd_zq_long
                                                     : cmd_decoder_pkg::cmd_zq_short;
          default: c = cmd_decoder_pkg::cmd_nop;
        endcase
      end
    end else if (cke_prev && !p.cke) begin
      if (quiet) begin
        c = cmd_decoder_pkg::cmd_pd_entry;
      end else if (!p.cs_b && ({p.ras_b, p.cas_b, p.we_b} == 3'h1)) begin
        c = cmd_decoder_pkg::cmd_sr_entry;
      end else begin
        c = cmd_decoder_pkg::cmd_none;
      end
    end else if (!cke_prev && p.cke && quiet) begin
      c = (st == cmd_decoder_pkg::st_self_refresh) ? cmd_decoder_pkg::cmd_sr_exit
                                                    : cmd_decoder_pkg::cmd_pd_exit;
    end
    return c;
  endfunction : decode

  // ---------------------------------------------------------------------------
  // Power state, command register and mode register
  // ---------------------------------------------------------------------------
  cmd_decoder_pkg::pwr_t pwr_reg;
  cmd_decoder_pkg::pwr_t pwr_next;
  cmd_decoder_pkg::cmd_t dec;
  cmd_decoder_pkg::cmd_info_t cmd_next;
  logic cke_prev_reg;
  logic valid_next;
  logic illegal_next;
  logic refresh_next;
  logic [1:0] bl_mode_reg;
  logic [1:0] bl_mode_next;
  logic [9:0] hold_cnt_reg;
  logic [9:0] hold_cnt_next;
  logic burst_start;

  assign dec = decode(pins, cke_prev_reg, pwr_reg);

  // Computes the next state, the decoded command and the stored burst mode.
  always_comb begin
    pwr_next = pwr_reg;
    cmd_next = '0;
    cmd_next.cmd = dec;
    cmd_next.bank = pins.ba;
    cmd_next.addr = pins.addr;
    valid_next = 1'b0;
    illegal_next = 1'b0;
    refresh_next = 1'b0;
    bl_mode_next = bl_mode_reg;
    hold_cnt_next = (hold_cnt_reg != '0) ? hold_cnt_reg - 10'h001 : hold_cnt_reg;
    case (pwr_reg)
      cmd_decoder_pkg::st_active: begin
        valid_next = (dec != cmd_decoder_pkg::cmd_none);
        illegal_next = (cke_prev_reg != pins.cke) && (dec == cmd_decoder_pkg::cmd_none);
        if (dec == cmd_decoder_pkg::cmd_pd_entry) begin
          pwr_next = cmd_decoder_pkg::st_power_down;
        end else if (dec == cmd_decoder_pkg::cmd_sr_entry) begin
          pwr_next = cmd_decoder_pkg::st_self_refresh;
        end
        refresh_next = (dec == cmd_decoder_pkg::cmd_refresh);
        if (dec == cmd_decoder_pkg::cmd_mode_set && pins.ba == cmd_decoder_pkg::MR0_SEL) begin
          bl_mode_next = pins.addr[cmd_decoder_pkg::BL_LSB +: 2];
        end
      end
      cmd_decoder_pkg::st_power_down: begin
        // No refresh happens here; pins are don't-care while CKE stays low.
        if (pins.cke) begin
          valid_next = (dec == cmd_decoder_pkg::cmd_pd_exit);
          illegal_next = (dec != cmd_decoder_pkg::cmd_pd_exit);
          pwr_next = cmd_decoder_pkg::st_active;
        end
      end
      cmd_decoder_pkg::st_self_refresh: begin
        // The CKE level alone ends self refresh, whatever the strobes show.
        if (pins.cke) begin
          valid_next = (dec == cmd_decoder_pkg::cmd_sr_exit);
          illegal_next = (dec != cmd_decoder_pkg::cmd_sr_exit);
          pwr_next = cmd_decoder_pkg::st_active;
          hold_cnt_next = 10'(cmd_decoder_pkg::SRX_WRITE_NCK);
        end
      end
      default: begin
        pwr_next = cmd_decoder_pkg::st_active;
      end
    endcase
    cmd_next.auto_pre = pins.addr[cmd_decoder_pkg::AP_BIT];
    case (bl_mode_reg)
      cmd_decoder_pkg::BL_OTF: cmd_next.chop4 = !pins.addr[cmd_decoder_pkg::BC_BIT];
      cmd_decoder_pkg::BL_FIXED4: cmd_next.chop4 = 1'b1;
      default: cmd_next.chop4 = 1'b0;
    endcase
    if (!valid_next) begin
      cmd_next = '0;
    end
  end

  // Registers the power state, command outputs and mode.
  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      pwr_reg <= cmd_decoder_pkg::st_active;
      cke_prev_reg <= 1'b1;
      cmd_out <= '0;
      cmd_valid <= 1'b0;
      illegal <= 1'b0;
      refresh_go <= 1'b0;
      bl_mode_reg <= cmd_decoder_pkg::BL_RESET;
      hold_cnt_reg <= '0;
      in_power_down <= 1'b0;
      in_self_refresh <= 1'b0;
      term_on <= 1'b0;
      write_hold <= 1'b0;
      burst_mode <= cmd_decoder_pkg::BL_RESET;
    end else begin
      pwr_reg <= pwr_next;
      cke_prev_reg <= pins.cke;
      cmd_out <= cmd_next;
      cmd_valid <= valid_next;
      illegal <= illegal_next;
      refresh_go <= refresh_next;
      bl_mode_reg <= bl_mode_next;
      hold_cnt_reg <= hold_cnt_next;
      in_power_down <= (pwr_next == cmd_decoder_pkg::st_power_down);
      in_self_refresh <= (pwr_next == cmd_decoder_pkg::st_self_refresh);
      term_on <= pins.odt && (pwr_next != cmd_decoder_pkg::st_self_refresh);
      write_hold <= (hold_cnt_next != '0);
      burst_mode <= bl_mode_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Burst tracking
  // ---------------------------------------------------------------------------
  assign burst_start = (cmd_out.cmd == cmd_decoder_pkg::cmd_read) ||
                       (cmd_out.cmd == cmd_decoder_pkg::cmd_write);

  burst_tracker #(
    .BEATS_MAX(cmd_decoder_pkg::BEATS8)
  ) u_burst (
    .clock(clock),
    .rst_q_b(rst_q_b),
    .start(burst_start),
    .chop4(cmd_out.chop4),
    .busy(burst_busy),
    .overlap(burst_overlap)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_q_b);

  sequence pd_enter_s;
    pwr_reg == cmd_decoder_pkg::st_active && cke_prev_reg && !pins.cke && pins.cs_b;
  endsequence

  sequence pd_wake_s;
    pwr_reg == cmd_decoder_pkg::st_power_down && pins.cke &&
      (pins.cs_b || ({pins.ras_b, pins.cas_b, pins.we_b} == 3'h7));
  endsequence

  deselect_decode_a: assert property (pwr_reg == cmd_decoder_pkg::st_active &&
      cke_prev_reg && pins.cke && pins.cs_b |=> cmd_out.cmd == cmd_decoder_pkg::cmd_deselect)
    else $error("deselect not decoded");
  write_decode_a: assert property (cmd_valid && cmd_out.cmd == cmd_decoder_pkg::cmd_write |->
      $past(!pins.cs_b && pins.ras_b && !pins.cas_b && !pins.we_b))
    else $error("write from wrong strobes");
  auto_pre_a: assert property (cmd_valid && cmd_out.cmd == cmd_decoder_pkg::cmd_read |->
      cmd_out.auto_pre == $past(pins.addr[cmd_decoder_pkg::AP_BIT]))
    else $error("auto precharge flag wrong");
  bank_pick_a: assert property (cmd_valid && cmd_out.cmd == cmd_decoder_pkg::cmd_activate |->
      cmd_out.bank == $past(pins.ba))
    else $error("activate bank wrong");
  mode_store_a: assert property (cmd_valid && cmd_out.cmd == cmd_decoder_pkg::cmd_mode_set &&
      cmd_out.bank == cmd_decoder_pkg::MR0_SEL |-> burst_mode == cmd_out.addr[1:0])
    else $error("burst mode not stored");
  pd_no_refresh_a: assert property (in_power_down |-> !refresh_go)
    else $error("refresh in power-down");
  sr_term_off_a: assert property (in_self_refresh |-> !term_on)
    else $error("termination on in self refresh");
  sr_exit_a: assert property (pwr_reg == cmd_decoder_pkg::st_self_refresh && pins.cke |=>
      !in_self_refresh ##0 write_hold [*8])
    else $error("self refresh exit missed");
  pd_cycle_a: assert property (pd_enter_s |=> in_power_down &&
      cmd_valid && cmd_out.cmd == cmd_decoder_pkg::cmd_pd_entry)
    else $error("power-down entry missed");
  pd_wake_a: assert property (pd_wake_s |=> !in_power_down && cmd_valid &&
      cmd_out.cmd == cmd_decoder_pkg::cmd_pd_exit)
    else $error("power-down exit missed");

endmodule : cmd_decoder

`default_nettype wire

// ### tb/ctrl_model.sv
// Behavioural memory controller that drives the command pins of the decoder.
// Assumes the bench calls drive and idle; every pin change lands 1 ns after a rising edge.
`default_nettype none

module ctrl_model (
  // Clock.
  input wire logic clock,
  // Command pins towards the device.
  output var cmd_decoder_pkg::pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  // Start deselected with clock enable high.
  initial begin
    pins = '0;
    pins.cs_b = 1'b1;
    pins.cke = 1'b1;
  end

  // Idle cycles deselect; the ignored pins change every cycle so stale values never help.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      pins.cs_b = 1'b1;
      {pins.ras_b, pins.cas_b, pins.we_b} = ~{pins.ras_b, pins.cas_b, pins.we_b};
      pins.ba = ~pins.ba;
      pins.addr = ~pins.addr;
    end
  endtask : idle

  // One command for one cycle with defined levels on every field; clock enable then holds.
  task automatic drive(input logic [3:0] enc, input logic cke_v, input logic odt_v,
                       input logic [cmd_decoder_pkg::BANK_W-1:0] ba_v,
                       input logic [cmd_decoder_pkg::ADDR_W-1:0] a_v);
    {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b} = enc;
    pins.cke = cke_v;
    pins.odt = odt_v;
    pins.ba = ba_v;
    pins.addr = a_v;
    idle(1);
  endtask : drive
endmodule : ctrl_model

`default_nettype wire

// ### tb/sdram_command_decoder_tb.sv
// Self-checking bench of the memory command decoder.
// Assumes the decoder answers three edges after a command is placed on the pins.
`default_nettype none

`define CHECK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module sdram_command_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic odt_lvl = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  cmd_decoder_pkg::pins_t pins;
  cmd_decoder_pkg::cmd_info_t cmd_out;
  logic cmd_valid, illegal, in_power_down, in_self_refresh, refresh_go;
  logic term_on, write_hold, burst_busy, burst_overlap;
  logic [1:0] burst_mode;

  // Clock of 8 ns.
  always #4 clock = ~clock;

  ctrl_model ctrl_u (.clock(clock), .pins(pins));

  cmd_decoder dut_u (
    .clock(clock), .rst_b(rst_b), .cs_b(pins.cs_b), .ras_b(pins.ras_b),
    .cas_b(pins.cas_b), .we_b(pins.we_b), .cke(pins.cke), .odt(pins.odt),
    .ba(pins.ba), .addr(pins.addr), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
    .illegal(illegal), .in_power_down(in_power_down), .in_self_refresh(in_self_refresh),
    .refresh_go(refresh_go), .term_on(term_on), .write_hold(write_hold),
    .burst_busy(burst_busy), .burst_overlap(burst_overlap), .burst_mode(burst_mode)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Issues one command and judges the decoded kind when it appears.
  task automatic one(input logic [3:0] enc, input logic cke_v,
                     input logic [cmd_decoder_pkg::BANK_W-1:0] ba_v,
                     input logic [cmd_decoder_pkg::ADDR_W-1:0] a_v,
                     input cmd_decoder_pkg::cmd_t exp_cmd);
    ctrl_u.drive(enc, cke_v, odt_lvl, ba_v, a_v);
    ctrl_u.idle(2);
    `CHECK(cmd_valid, 1'b1)
    `CHECK(cmd_out.cmd, exp_cmd)
  endtask : one

  // Counts cycles of burst activity, overlap pulses and write hold over a span.
  task automatic count_high(input int n, output int busy_n, output int ovl_n,
                            output int hold_n);
    busy_n = 0;
    ovl_n = 0;
    hold_n = 0;
    repeat (n) begin
      ctrl_u.idle(1);
      busy_n += (burst_busy === 1'b1);
      ovl_n += (burst_overlap === 1'b1);
      hold_n += (write_hold === 1'b1);
    end
  endtask : count_high

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Every plain command kind except read and write, with termination requests flipping between them.
  task automatic t_commands;
    one(4'h0, 1'b1, 3'h0, {13'h0, cmd_decoder_pkg::BL_OTF}, cmd_decoder_pkg::cmd_mode_set);
    `CHECK(burst_mode, cmd_decoder_pkg::BL_OTF)
    odt_lvl = 1'b1;
    one(4'h1, 1'b1, 3'h2, 15'h1234, cmd_decoder_pkg::cmd_refresh);
    `CHECK(refresh_go, 1'b1)
    one(4'h2, 1'b1, 3'h5, 15'h0000, cmd_decoder_pkg::cmd_precharge);
    `CHECK(cmd_out.bank, 3'h5)
    odt_lvl = 1'b0;
    one(4'h2, 1'b1, 3'h1, 15'h0400, cmd_decoder_pkg::cmd_precharge_all);
    one(4'h3, 1'b1, 3'h3, 15'h5abc, cmd_decoder_pkg::cmd_activate);
    `CHECK(cmd_out.bank, 3'h3)
    `CHECK(cmd_out.addr, 15'h5abc)
    one(4'h6, 1'b1, 3'h0, 15'h0400, cmd_decoder_pkg::cmd_zq_long);
    one(4'h6, 1'b1, 3'h7, 15'h7bff, cmd_decoder_pkg::cmd_zq_short);
    one(4'h7, 1'b1, 3'h4, 15'h0400, cmd_decoder_pkg::cmd_nop);
    one(4'h8, 1'b1, 3'h0, 15'h0000, cmd_decoder_pkg::cmd_deselect);
  endtask : t_commands

  // Bursts of both lengths, a second read during a burst and a no-op after it.
  task automatic t_burst;
    int b, o, h;
    one(4'h4, 1'b1, 3'h2, 15'h0407, cmd_decoder_pkg::cmd_write);
    `CHECK({cmd_out.auto_pre, cmd_out.chop4}, 2'h3)
    count_high(8, b, o, h);
    `CHECK(b, cmd_decoder_pkg::BEATS4)
    one(4'h5, 1'b1, 3'h6, 15'h1010, cmd_decoder_pkg::cmd_read);
    `CHECK({cmd_out.auto_pre, cmd_out.chop4, cmd_out.bank}, 5'h06)
    count_high(8, b, o, h);
    `CHECK(b, cmd_decoder_pkg::BEATS8)
    // An eight-beat read, a chopped read inside it and a no-op right after.
    ctrl_u.drive(4'h5, 1'b1, odt_lvl, 3'h1, 15'h1000);
    ctrl_u.drive(4'h5, 1'b1, odt_lvl, 3'h1, 15'h0008);
    ctrl_u.drive(4'h7, 1'b1, odt_lvl, 3'h1, 15'h0000);
    count_high(10, b, o, h);
    `CHECK(b, cmd_decoder_pkg::BEATS8)
    `CHECK(o, 1)
    one(4'h0, 1'b1, 3'h0, {13'h0, cmd_decoder_pkg::BL_FIXED4}, cmd_decoder_pkg::cmd_mode_set);
    one(4'h5, 1'b1, 3'h0, 15'h1000, cmd_decoder_pkg::cmd_read);
    `CHECK(cmd_out.chop4, 1'b1)
    count_high(8, b, o, h);
    `CHECK(b, cmd_decoder_pkg::BEATS4)
  endtask : t_burst

  // Power-down entry and exit on deselect and no-op; a refresh inside is ignored.
  task automatic t_power_down;
    one(4'h8, 1'b0, 3'h0, 15'h0000, cmd_decoder_pkg::cmd_pd_entry);
    `CHECK(in_power_down, 1'b1)
    ctrl_u.drive(4'h1, 1'b0, odt_lvl, 3'h0, 15'h0000);
    ctrl_u.idle(2);
    `CHECK({cmd_valid, refresh_go}, 2'h0)
    one(4'h7, 1'b1, 3'h0, 15'h0000, cmd_decoder_pkg::cmd_pd_exit);
    `CHECK(in_power_down, 1'b0)
  endtask : t_power_down

  // Self refresh with termination requested, then exit and the write hold span.
  task automatic t_self_refresh;
    int b, o, h;
    odt_lvl = 1'b1;
    one(4'h1, 1'b0, 3'h0, 15'h0000, cmd_decoder_pkg::cmd_sr_entry);
    ctrl_u.idle(1);
    `CHECK({in_self_refresh, term_on}, 2'h2)
    one(4'h8, 1'b1, 3'h0, 15'h0000, cmd_decoder_pkg::cmd_sr_exit);
    `CHECK({in_self_refresh, write_hold}, 2'h1)
    count_high(600, b, o, h);
    // The exit cycle itself was already seen above, so the span holds one cycle less.
    `CHECK(h, cmd_decoder_pkg::SRX_WRITE_NCK - 1)
    `CHECK(term_on, 1'b1)
    odt_lvl = 1'b0;
    one(4'h4, 1'b1, 3'h0, 15'h0000, cmd_decoder_pkg::cmd_write);
  endtask : t_self_refresh

  // A clock enable fall with a row open command is not a valid transition.
  task automatic t_illegal;
    ctrl_u.drive(4'h3, 1'b0, odt_lvl, 3'h0, 15'h0000);
    ctrl_u.idle(2);
    `CHECK(illegal, 1'b1)
  endtask : t_illegal

  // ---------------------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // Reset for 10 cycles, then held high for the whole run.
  initial begin
    repeat (10) @(posedge clock);
    #1 rst_b = 1'b1;
    ctrl_u.idle(8);
    t_commands();
    t_burst();
    t_power_down();
    t_self_refresh();
    t_illegal();
    summarize();
  end

  // Watchdog well beyond the expected run of about 720 cycles.
  initial begin
    #16000;
    num_errors++;
    summarize();
  end
endmodule : sdram_command_decoder_tb

`default_nettype wire
